// ---- rtl/bopt_bus_options.v ----
/*
 * Bus capability options register: one 32-bit word of node
 * capabilities, clock accuracy, max request code, generation counter
 * and a constant link speed, reached over an AXI4-Lite slave port.
 * Assumes the two pin resets are asynchronous active-low levels, and
 * that soft_reset, bus_reset, rom_changed and block write requests come
 * from logic on aclk as one-cycle pulses.
 * Limitation: software is trusted to keep the fields sane while the
 * link runs; nothing here is locked by link_active_enable.
 */
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/100ps

`include "bopt_defs.vh"

// What this block does
// - four capability flags, bits 31-28, reset zero
// - power management flag bit 27, reset zero
// - reserved bits read zero, writes ignored
// - clock accuracy field bits 23-16, reset zero
// - max request code bits 15-12, at least 512
// - hardware reset loads 4096 code; soft keeps
// - oversize block write may get type error
// - generation counter bits 7-6 advances at bus reset after change
// - constant link speed code 3 in bits 2-0
// - pin resets restore max request default
// - register sits at byte offset 20h
// - reset word reads 0000 B003h
module bopt_bus_options (
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // resets beyond aresetn
    input  wire        express_fundamental_reset_n,
    input  wire        function_reset_input_n,
    input  wire        soft_reset,
    // link side events
    input  wire        link_active_enable,
    input  wire        bus_reset,
    input  wire        rom_changed,
    input  wire        blk_wr_req,
    input  wire [15:0] blk_wr_len,
    output reg         blk_wr_type_err,
    // field values to the link core
    output reg         irm_capable,
    output reg         cycle_master_capable,
    output reg         iso_capable,
    output reg         bus_manager_capable,
    output reg         power_mgmt_capable,
    output reg  [7:0]  cyc_clk_accuracy,
    output reg  [3:0]  max_request_code,
    output reg  [1:0]  generation
);

    ////////////////////////////////////////////////////////////////////////
    // pin reset synchronisers

    wire [1:0] pin_raw;
    wire [1:0] pin_level;

    assign pin_raw = {function_reset_input_n, express_fundamental_reset_n};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
            bopt_pin_sync #(
                .RESET_LEVEL (1'b1)
            ) u_sync (
                .aclk    (aclk),
                .aresetn (aresetn),
                .pin_in  (pin_raw[gi]),
                .level_q (pin_level[gi])
            );
        end
    endgenerate

    wire maxrec_restore;

    // the pin path adds four to five edges each way; only the max
    // request code listens, every other field keeps its value
    // either pin low holds the max request code at its default
    assign maxrec_restore = ~(&pin_level);

    ////////////////////////////////////////////////////////////////////////
    // read view of the register

    wire [31:0] reg_word;

    assign reg_word = {irm_capable, cycle_master_capable, iso_capable,
                       bus_manager_capable, power_mgmt_capable,
                       3'h0,
                       cyc_clk_accuracy,
                       max_request_code,
                       4'h0,
                       generation,
                       3'h0,
                       `BOPT_LINK_SPEED};

    ////////////////////////////////////////////////////////////////////////
    // write channel capture

    reg        aw_held_q;
    reg [7:0]  awaddr_q;
    reg        w_held_q;
    reg [31:0] wdata_q;
    reg [3:0]  wstrb_q;

    wire aw_take;
    wire w_take;
    wire wr_fire;
    wire wr_hit;

    // awready and wready idle high; each drops at its own handshake and
    // stays low until the response is taken, so one write is in flight.
    // the register changes at the edge that raises bvalid
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take  = s_axi_wvalid & s_axi_wready;
    assign wr_fire = aw_held_q & w_held_q & ~s_axi_bvalid;
    assign wr_hit  = ({awaddr_q[7:2], 2'h0} == `BOPT_OPTIONS_OFFSET);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q     <= 1'b0;
            awaddr_q      <= 8'h00;
            w_held_q      <= 1'b0;
            wdata_q       <= 32'h00000000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `BOPT_RESP_OKAY;
        end else begin
            if (!aw_held_q && !s_axi_bvalid && !aw_take) begin
                s_axi_awready <= 1'b1;
            end
            if (!w_held_q && !s_axi_bvalid && !w_take) begin
                s_axi_wready <= 1'b1;
            end
            if (aw_take) begin
                aw_held_q     <= 1'b1;
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_held_q     <= 1'b1;
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `BOPT_RESP_OKAY : `BOPT_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write merge: byte enables and the writable mask together

    wire [31:0] byte_mask;
    wire [31:0] wr_mask;
    wire [31:0] merged;
    wire        reg_write;
    wire        maxrec_ok;

    assign byte_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                        {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign wr_mask   = byte_mask & `BOPT_WR_MASK;
    assign merged    = (reg_word & ~wr_mask) | (wdata_q & wr_mask);
    assign reg_write = wr_fire & wr_hit;

    // codes below 8 would advertise under 512 bytes; such a code is dropped, the other fields still take the write
    assign maxrec_ok = (merged[`BOPT_MAXREC_HI:`BOPT_MAXREC_LO] >=
                        `BOPT_MAXREC_MIN);

    ////////////////////////////////////////////////////////////////////////
    // field slices of the merged word; a lane that was not written carries
    // the field's present value through

    wire        wr_irm;
    wire        wr_cmc;
    wire        wr_isc;
    wire        wr_bmc;
    wire        wr_pmc;
    wire [7:0]  wr_acc;
    wire [3:0]  wr_code;
    wire [1:0]  wr_gen;

    assign wr_irm  = merged[`BOPT_IRMC_BIT];
    assign wr_cmc  = merged[`BOPT_CMC_BIT];
    assign wr_isc  = merged[`BOPT_ISC_BIT];
    assign wr_bmc  = merged[`BOPT_BMC_BIT];
    assign wr_pmc  = merged[`BOPT_PMC_BIT];
    assign wr_acc  = merged[`BOPT_ACC_HI:`BOPT_ACC_LO];
    assign wr_code = merged[`BOPT_MAXREC_HI:`BOPT_MAXREC_LO];
    assign wr_gen  = merged[`BOPT_GEN_HI:`BOPT_GEN_LO];

    ////////////////////////////////////////////////////////////////////////
    // capability flags and clock accuracy
    // software is trusted to have these valid before link_active_enable;
    // the block does not lock them while the link runs

    always @(posedge aclk) begin
        if (!aresetn || soft_reset) begin
            irm_capable          <= `BOPT_FLAG_RESET;
            cycle_master_capable <= `BOPT_FLAG_RESET;
            iso_capable          <= `BOPT_FLAG_RESET;
            bus_manager_capable  <= `BOPT_FLAG_RESET;
            power_mgmt_capable   <= `BOPT_FLAG_RESET;
            cyc_clk_accuracy     <= `BOPT_ACC_RESET;
        end else if (reg_write) begin
            irm_capable          <= wr_irm;
            cycle_master_capable <= wr_cmc;
            iso_capable          <= wr_isc;
            bus_manager_capable  <= wr_bmc;
            power_mgmt_capable   <= wr_pmc;
            cyc_clk_accuracy     <= wr_acc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // max request code: soft reset deliberately absent here

    always @(posedge aclk) begin
        if (!aresetn || maxrec_restore) begin
            max_request_code <= `BOPT_MAXREC_RESET;
        end else if (reg_write && maxrec_ok) begin
            max_request_code <= wr_code;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // generation counter

    reg rom_dirty_q;

    wire dirty_now;

    // the dirty flag lasts until the next bus reset; a change and a bus reset in one
    // cycle advance the counter once and leave the flag clear
    // a change in the same cycle as the bus reset still counts
    assign dirty_now = rom_dirty_q | rom_changed;

    always @(posedge aclk) begin
        if (!aresetn || soft_reset) begin
            rom_dirty_q <= 1'b0;
        end else if (bus_reset) begin
            rom_dirty_q <= 1'b0;
        end else if (rom_changed) begin
            rom_dirty_q <= 1'b1;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn || soft_reset) begin
            generation <= `BOPT_GEN_RESET;
        end else if (reg_write && wstrb_q[0]) begin
            // software write wins over a same-cycle advance
            generation <= wr_gen;
        end else if (bus_reset && dirty_now) begin
            generation <= generation + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // oversize block write check

    wire [16:0] max_rec_bytes;
    wire [4:0]  shift_amt;

    // code F gives 2^16, so the limit needs 17 bits to hold it; a length
    // equal to the limit is legal, only a longer one is flagged
    assign shift_amt     = {1'b0, max_request_code} + 5'h01;
    assign max_rec_bytes = 17'h00001 << shift_amt;

    always @(posedge aclk) begin
        if (!aresetn) begin
            blk_wr_type_err <= 1'b0;
        end else begin
            blk_wr_type_err <= blk_wr_req &&
                               ({1'b0, blk_wr_len} > max_rec_bytes);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel

    wire ar_take;
    wire rd_hit;

    // reads need no wait state: rdata loads at the address edge, so a
    // write landing at that same edge shows only on the next read
    assign ar_take = s_axi_arvalid & s_axi_arready;
    assign rd_hit  = ({s_axi_araddr[7:2], 2'h0} == `BOPT_OPTIONS_OFFSET);

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `BOPT_RESP_OKAY;
        end else begin
            if (!s_axi_rvalid && !ar_take) begin
                s_axi_arready <= 1'b1;
            end
            if (ar_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_hit ? reg_word : 32'h00000000;
                s_axi_rresp   <= rd_hit ? `BOPT_RESP_OKAY : `BOPT_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // link_active_enable is informational only here; locking the fields
    // while the link runs would refuse writes that software is trusted with
    wire unused_link;
    assign unused_link = link_active_enable;

endmodule // bopt_bus_options

// ---- rtl/bopt_defs.vh ----
/*
 * Constants for the bus capability options register block: bus map,
 * field positions, reset values and write masks.
 * Assumes inclusion by bare name from the rtl files only.
 */
`ifndef BOPT_DEFS_VH
`define BOPT_DEFS_VH

// byte address of the register and the decode width
`define BOPT_ADDR_W          8
`define BOPT_OPTIONS_OFFSET  8'h20

// field positions
`define BOPT_IRMC_BIT        31
`define BOPT_CMC_BIT         30
`define BOPT_ISC_BIT         29
`define BOPT_BMC_BIT         28
`define BOPT_PMC_BIT         27
`define BOPT_ACC_HI          23
`define BOPT_ACC_LO          16
`define BOPT_MAXREC_HI       15
`define BOPT_MAXREC_LO       12
`define BOPT_GEN_HI          7
`define BOPT_GEN_LO          6
`define BOPT_SPD_HI          2
`define BOPT_SPD_LO          0

// reset values and constants
`define BOPT_FLAG_RESET      1'b0
`define BOPT_ACC_RESET       8'h00
`define BOPT_MAXREC_RESET    4'hB
`define BOPT_MAXREC_MIN      4'h8
`define BOPT_GEN_RESET       2'h0
`define BOPT_LINK_SPEED      3'h3

// bits that software may change; everything else is reserved or constant
`define BOPT_WR_MASK         32'hF8FFF0C0

// bus responses
`define BOPT_RESP_OKAY       2'h0
`define BOPT_RESP_SLVERR     2'h2

`endif

// ---- rtl/bopt_pin_sync.v ----
/*
 * Three-stage synchroniser for one asynchronous pin.
 * Assumes the pin is quasi-static; the output moves only once the
 * second and third stages agree, so a one-stage glitch is dropped.
 */
`timescale 1ns/100ps

module bopt_pin_sync #(
    parameter RESET_LEVEL = 1'b1
) (
    input  wire aclk,
    input  wire aresetn,
    input  wire pin_in,
    output reg  level_q
);

    reg s1_q;
    reg s2_q;
    reg s3_q;

    // s1_q feeds s2_q only, to keep metastability out of any logic
    always @(posedge aclk) begin
        if (!aresetn) begin
            s1_q    <= RESET_LEVEL;
            s2_q    <= RESET_LEVEL;
            s3_q    <= RESET_LEVEL;
            level_q <= RESET_LEVEL;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end

endmodule // bopt_pin_sync

// ---- testbench/bopt_bus_options_asserts.sv ----
/*
 * Checker for the bus capability options register, seen at its ports.
 * Assumes it is bound to bopt_bus_options and picks up the ports by name.
 */
`timescale 1ns/100ps

module bopt_chk (
    input wire        aclk,
    input wire        aresetn,
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        express_fundamental_reset_n,
    input wire        function_reset_input_n,
    input wire        soft_reset,
    input wire        bus_reset,
    input wire        rom_changed,
    input wire        blk_wr_req,
    input wire [15:0] blk_wr_len,
    input wire        blk_wr_type_err,
    input wire        irm_capable,
    input wire        cycle_master_capable,
    input wire        iso_capable,
    input wire        bus_manager_capable,
    input wire        power_mgmt_capable,
    input wire [7:0]  cyc_clk_accuracy,
    input wire [3:0]  max_request_code,
    input wire [1:0]  generation
);
    wire [4:0] flags = {irm_capable, cycle_master_capable, iso_capable,
                        bus_manager_capable, power_mgmt_capable};
    // rom change seen since the last bus reset; soft reset forgets it
    reg        dirty_q;
    always @(posedge aclk) begin
        if (!aresetn || soft_reset || bus_reset)
            dirty_q <= 1'h0;
        else if (rom_changed)
            dirty_q <= 1'h1;
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // pin synchronisers take 4-5 edges, so six low samples is safe
    sequence s_pin_low;
        (!express_fundamental_reset_n || !function_reset_input_n) [*6];
    endsequence
    a_rst_values: assert property ($rose(aresetn) |->
        flags == 5'h0 && cyc_clk_accuracy == 8'h00 && max_request_code == 4'hB
        && generation == 2'h0) else $error("field values wrong after reset");
    a_rdata_const: assert property (s_axi_rvalid && s_axi_rresp == 2'h0 |->
        (s_axi_rdata & 32'h07000F3F) == 32'h00000003) else $error("constant bits wrong");
    a_type_err: assert property (blk_wr_req |=> blk_wr_type_err ==
        ($past(blk_wr_len) > (17'h00001 << ($past(max_request_code) + 5'h01))))
        else $error("type error flag wrong");
    a_soft_clear: assert property (soft_reset |=> flags == 5'h0
        && cyc_clk_accuracy == 8'h00 && generation == 2'h0) else $error("soft reset missed");
    a_min_code: assert property (max_request_code >= 4'h8)
        else $error("max request code below 512 bytes");
    a_gen_step: assert property (bus_reset && !soft_reset && (dirty_q || rom_changed)
        |=> generation == $past(generation) + 2'h1) else $error("generation did not advance");
    a_wr_decode: assert property (s_wr_taken |-> ##2 s_axi_bvalid && s_axi_bresp ==
        ((($past(s_axi_awaddr, 2) >> 2) == 8'h08) ? 2'h0 : 2'h2))
        else $error("write answer wrong");
    a_pin_restore: assert property (s_pin_low |=> max_request_code == 4'hB)
        else $error("pin reset did not restore max code");
endmodule // bopt_chk

// ---- testbench/test_bus_options_register.sv ----
/*
 * Self-checking bench for the bus capability options register.
 * Assumes the rtl files are compiled first; drives every port itself.
 */
`timescale 1ns/100ps

module test_bus_options_register;
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, rd;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, soft_reset = 1'h0;
    logic        express_fundamental_reset_n = 1'h1, function_reset_input_n = 1'h1;
    logic        link_active_enable = 1'h0; // off; the dut only ties it to an unused wire
    logic        bus_reset = 1'h0, rom_changed = 1'h0, blk_wr_req = 1'h0;
    logic [15:0] blk_wr_len = 16'h0;
    logic [1:0]  resp;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire         blk_wr_type_err, irm_capable, cycle_master_capable, iso_capable;
    wire         bus_manager_capable, power_mgmt_capable;
    wire [1:0]   s_axi_bresp, s_axi_rresp, generation;
    wire [31:0]  s_axi_rdata;
    wire [7:0]   cyc_clk_accuracy;
    wire [3:0]   max_request_code;
    wire [31:0]  fields = {irm_capable, cycle_master_capable, iso_capable, bus_manager_capable,
                           power_mgmt_capable, 3'h0, cyc_clk_accuracy, max_request_code, 4'h0,
                           generation, 6'h0};
    int          mismatches = 0, n_compared = 0;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [1:0] r;
                    logic [31:0] q;} bopt_row_t;
    // applied in order: the read-backs of rows 1, 3, 4 and 5 depend on the rows before them
    bopt_row_t   rows [6] = '{
        '{8'h20, 32'hFFFFFFFF, 4'hF, 2'h0, 32'hF8FFF0C3},
        '{8'h20, 32'h00000000, 4'hF, 2'h0, 32'h0000F003},
        '{8'h20, 32'h12348000, 4'hF, 2'h0, 32'h10348003},
        '{8'h24, 32'hFFFFFFFF, 4'hF, 2'h2, 32'h10348003},
        '{8'h20, 32'hFFFFFFFF, 4'h1, 2'h0, 32'h103480C3},
        '{8'h20, 32'h0000A000, 4'h2, 2'h0, 32'h1034A0C3}};

    bopt_bus_options u_dut (.*);

    always #12.5 aclk = ~aclk;
    ////////////////////////////////////////////////////////////
    task automatic check_word(input string name, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic complete_run;
        if (mismatches == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    task automatic blk(input logic [15:0] n, input logic e);
        @(posedge aclk);
        blk_wr_req <= 1'h1;
        blk_wr_len <= n;
        @(posedge aclk);
        blk_wr_req <= 1'h0;
        @(posedge aclk);
        check_word("type error", {31'h0, e}, {31'h0, blk_wr_type_err});
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        axi_rd(8'h20);
        check_word("reset word", 32'h0000B003, rd);
        check_word("read resp", 32'h0, {30'h0, resp});
        foreach (rows[i]) begin
            axi_wr(rows[i].a, rows[i].d, rows[i].s);
            check_word("bresp", {30'h0, rows[i].r}, {30'h0, resp});
            axi_rd(8'h20);
            check_word("readback", rows[i].q, rd);
            check_word("field outputs", rows[i].q & 32'hF8FFF0C0, fields);
        end
        axi_rd(8'h24);
        check_word("unmapped read", 32'h00000002, {rd[31:2], resp});
        blk(16'h0800, 1'h0);
        blk(16'h0801, 1'h1);
        rom_changed <= 1'h1;
        @(posedge aclk);
        rom_changed <= 1'h0;
        bus_reset <= 1'h1;
        @(posedge aclk);
        bus_reset <= 1'h0;
        @(posedge aclk);
        check_word("generation wrap", 32'h0, {30'h0, generation});
        bus_reset <= 1'h1;
        @(posedge aclk);
        bus_reset <= 1'h0;
        @(posedge aclk);
        check_word("generation held", 32'h0, {30'h0, generation});
        soft_reset <= 1'h1;
        @(posedge aclk);
        soft_reset <= 1'h0;
        axi_rd(8'h20);
        check_word("soft reset word", 32'h0000A003, rd);
        for (int k = 0; k < 2; k++) begin
            axi_wr(8'h20, 32'h00009000, 4'hF);
            {express_fundamental_reset_n, function_reset_input_n} <= (k == 0) ? 2'h1 : 2'h2;
            repeat (8) @(posedge aclk);
            check_word("code in pin reset", 32'hB, {28'h0, max_request_code});
            {express_fundamental_reset_n, function_reset_input_n} <= 2'h3;
            repeat (8) @(posedge aclk);
            axi_rd(8'h20);
            check_word("pin reset word", 32'h0000B003, rd);
        end
        axi_wr(8'h20, 32'hFFFFFFFF, 4'hF);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        axi_rd(8'h20);
        check_word("second reset word", 32'h0000B003, rd);
        complete_run;
    end

    // the whole sequence needs about 120 cycles
    initial begin
        repeat (3000) @(posedge aclk);
        mismatches++;
        complete_run;
    end
endmodule // test_bus_options_register

bind bopt_bus_options bopt_chk u_chk (.*);
